// [common/wake_pkg.sv]
package wake_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [11:0] INT_STATUS_OFS = 12'h058;
   localparam logic [11:0] INT_ENABLE_OFS = 12'h05C;
   localparam logic [11:0] INT_CLEAR_OFS = 12'h060;
   localparam logic [11:0] HW_CONFIG_OFS = 12'h074;
   localparam logic [11:0] PMC_OFS = 12'h084;
   localparam logic [11:0] RESET_CONTROL_OFS = 12'h1F8;

   // Field positions of power_mgmt_control
   localparam int PMC_READY_BIT = 0;
   localparam int PMC_PIN_EN_BIT = 1;
   localparam int PMC_POL_BIT = 2;
   localparam int PMC_PULSE_BIT = 3;
   localparam int PMC_STS_BIT = 5;
   localparam int PMC_TYPE_BIT = 6;
   localparam int PMC_FRAME_EN_BIT = 9;

   // Field positions of the other registers
   localparam int HWCFG_SOFT_RST_BIT = 0;
   localparam int HWCFG_READY_BIT = 27;
   localparam int RSTCTL_DIGITAL_BIT = 0;
   localparam int INT_READY_BIT = 0;
   localparam int INT_WAKE_BIT = 1;
   localparam int INT_W = 2;

   // Reset values
   localparam logic [31:0] PMC_RESET = 32'h0000_0000;
   localparam logic [INT_W-1:0] INT_RESET = 2'h0;

   // Timing
   localparam int CLK_HZ = 25_000_000;
   localparam int PULSE_MS = 50;
   localparam int PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);
   localparam int STABLE_US = 20;
   localparam int STABLE_CYCLES = STABLE_US * (CLK_HZ / 1_000_000);

   // Ready sequencer states, Gray along hold -> count -> ready
   typedef enum logic [1:0] {
      RS_HOLD = 2'b00,
      RS_COUNT = 2'b01,
      RS_READY = 2'b11
   } ready_state_e;

endpackage : wake_pkg

// [rtl/wake_pulse_timer.sv]
`timescale 1ns/100ps
module wake_pulse_timer #(
   parameter int CYCLES = wake_pkg::PULSE_CYCLES,
   parameter int CNT_W = 21
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic abort,
   output logic busy
);

   initial
   begin
      if (CYCLES < 1 || CYCLES >= (1 << CNT_W))
         $error("wake_pulse_timer: CYCLES does not fit CNT_W");
   end

   logic [CNT_W-1:0] count_r;

   ////////////////////////////////////////////////////////////////////////
   // Down counter; busy is high for exactly CYCLES cycles after start
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         count_r <= '0;
      else if (abort)
         count_r <= '0;
      else if (start)
         count_r <= CNT_W'(CYCLES);
      else if (count_r != '0)
         count_r <= count_r - 1'b1;
   end

   assign busy = (count_r != '0);

endmodule : wake_pulse_timer

// [rtl/ready_sequencer.sv]
`timescale 1ns/100ps
module ready_sequencer #(
   parameter int CYCLES = wake_pkg::STABLE_CYCLES,
   parameter int CNT_W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic restart,
   output logic ready
);

   initial
   begin
      if (CYCLES < 1 || CYCLES >= (1 << CNT_W))
         $error("ready_sequencer: CYCLES does not fit CNT_W");
   end

   wake_pkg::ready_state_e state_r;
   logic [CNT_W-1:0] count_r;

   ////////////////////////////////////////////////////////////////////////
   // Hold, then wait out the settling time, then report ready
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= wake_pkg::RS_HOLD;
         count_r <= '0;
      end
      else if (restart)
      begin
         state_r <= wake_pkg::RS_HOLD;
         count_r <= '0;
      end
      else
      begin
         unique case (state_r)
            wake_pkg::RS_HOLD:
            begin
               state_r <= wake_pkg::RS_COUNT;
               count_r <= CNT_W'(CYCLES);
            end
            wake_pkg::RS_COUNT:
            begin
               if (count_r == CNT_W'(1))
                  state_r <= wake_pkg::RS_READY;
               count_r <= count_r - 1'b1;
            end
            wake_pkg::RS_READY:
               count_r <= '0;
            default:
               state_r <= wake_pkg::RS_HOLD;
         endcase
      end
   end

   assign ready = (state_r == wake_pkg::RS_READY);

endmodule : ready_sequencer

// [rtl/wake_event_output_control.sv]
`timescale 1ns/100ps

// Operation
// - Drive-type bit 6 zero gives open-drain wake pin, one gives push-pull.
// - Open-drain mode ignores polarity and always drives active low.
// - Polarity bit 2: one is active high, zero is active low.
// - Bit 3 one pulses wake output for 50 ms, zero holds it active.
// - Clearing wake-frame status or its enable deasserts the wake output.
// - Pin enable bit 1 gates the wake output pin.
// - Pin enable does not affect the wake interrupt status bit.
// - Status bit 5 set by wake frame or magic packet; write one clears.
// - Status clears only after the host MAC source event is cleared too.
// - Ready bit 0 zero after any reset, one once device is stable.
// - Ready bit can raise a host interrupt when enabled.
// - Ready bit always equals bit 27 of hardware config register.
// - Soft reset keeps drive type and polarity, resets other control bits.
// - Enabled wake frame drives pin per indication mode and sets interrupt.
module wake_event_output_control #(
   parameter int PULSE_CYCLES = wake_pkg::PULSE_CYCLES,
   parameter int PULSE_CNT_W = 21,
   parameter int STABLE_CYCLES = wake_pkg::STABLE_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic wake_frame_source,
   output logic wake_event_output_o,
   output logic wake_event_output_oe,
   output logic irq
);

   initial
   begin
      if (PULSE_CYCLES < 1 || STABLE_CYCLES < 1)
         $error("wake_event_output_control: cycle counts must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam int INT_W_L = wake_pkg::INT_W;

   logic addr_phase;
   logic wr_pend_r;
   logic [11:0] wr_addr_r;
   logic wr_pmc;
   logic wr_int_en;
   logic wr_int_clr;
   logic soft_reset;
   logic digital_reset;
   logic sys_clear;
   logic [31:0] rd_data;

   logic drive_type_r;
   logic polarity_r;
   logic pulse_sel_r;
   logic pin_en_r;
   logic frame_en_r;
   logic frame_sts_r;
   logic frame_sts_nxt;

   logic ready;
   logic ready_d_r;
   logic [INT_W_L-1:0] interrupt_status_reg_r;
   logic [INT_W_L-1:0] interrupt_status_reg_nxt;
   logic [INT_W_L-1:0] int_en_r;
   logic [INT_W_L-1:0] int_set;

   logic wake_cond;
   logic wake_cond_d_r;
   logic wake_rise;
   logic pulse_busy;
   logic indicate;
   logic pin_o_nxt;
   logic pin_oe_nxt;

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY

   // A transfer is taken when selected, non-idle and the bus is ready
   assign addr_phase = hsel && htrans[1] && hready;

   // Writes are held until the data phase, where hwdata is valid
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
      end
      else if (hready)
      begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= haddr[11:0];
      end
   end

   // Only whole-word writes are expected; narrower sizes still act on the word
   assign wr_pmc = wr_pend_r && (wr_addr_r == wake_pkg::PMC_OFS);
   assign wr_int_en = wr_pend_r && (wr_addr_r == wake_pkg::INT_ENABLE_OFS);
   assign wr_int_clr = wr_pend_r && (wr_addr_r == wake_pkg::INT_CLEAR_OFS);
   assign soft_reset = wr_pend_r && (wr_addr_r == wake_pkg::HW_CONFIG_OFS)
                       && hwdata[wake_pkg::HWCFG_SOFT_RST_BIT];
   assign digital_reset = wr_pend_r && (wr_addr_r == wake_pkg::RESET_CONTROL_OFS)
                          && hwdata[wake_pkg::RSTCTL_DIGITAL_BIT];
   assign sys_clear = soft_reset || digital_reset;

   // Read mux; unmapped and write-only addresses read zero
   always_comb
   begin
      rd_data = 32'h0000_0000;
      unique case (haddr[11:0])
         wake_pkg::PMC_OFS:
         begin
            rd_data[wake_pkg::PMC_READY_BIT] = ready;
            rd_data[wake_pkg::PMC_PIN_EN_BIT] = pin_en_r;
            rd_data[wake_pkg::PMC_POL_BIT] = polarity_r;
            rd_data[wake_pkg::PMC_PULSE_BIT] = pulse_sel_r;
            rd_data[wake_pkg::PMC_STS_BIT] = frame_sts_r;
            rd_data[wake_pkg::PMC_TYPE_BIT] = drive_type_r;
            rd_data[wake_pkg::PMC_FRAME_EN_BIT] = frame_en_r;
         end
         wake_pkg::HW_CONFIG_OFS:
            rd_data[wake_pkg::HWCFG_READY_BIT] = ready;
         wake_pkg::INT_STATUS_OFS:
            rd_data[INT_W_L-1:0] = interrupt_status_reg_r;
         wake_pkg::INT_ENABLE_OFS:
            rd_data[INT_W_L-1:0] = int_en_r;
         default:
            rd_data = 32'h0000_0000;
      endcase
   end

   // Read data is captured at the address phase edge and stands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_phase && !hwrite)
         hrdata <= rd_data;
   end

   // No wait states and no error responses; both flops settle after reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power management control fields

   // Drive type and polarity survive a soft reset, but not a digital reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         drive_type_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_TYPE_BIT];
         polarity_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_POL_BIT];
      end
      else if (digital_reset)
      begin
         drive_type_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_TYPE_BIT];
         polarity_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_POL_BIT];
      end
      else if (wr_pmc)
      begin
         drive_type_r <= hwdata[wake_pkg::PMC_TYPE_BIT];
         polarity_r <= hwdata[wake_pkg::PMC_POL_BIT];
      end
   end

   // Ordinary control bits go back to defaults on either soft or digital reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pulse_sel_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_PULSE_BIT];
         pin_en_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_PIN_EN_BIT];
         frame_en_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_FRAME_EN_BIT];
      end
      else if (sys_clear)
      begin
         pulse_sel_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_PULSE_BIT];
         pin_en_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_PIN_EN_BIT];
         frame_en_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_FRAME_EN_BIT];
      end
      else if (wr_pmc)
      begin
         pulse_sel_r <= hwdata[wake_pkg::PMC_PULSE_BIT];
         pin_en_r <= hwdata[wake_pkg::PMC_PIN_EN_BIT];
         frame_en_r <= hwdata[wake_pkg::PMC_FRAME_EN_BIT];
      end
   end

   // Wake-frame status: the source level sets it, and while the MAC still
   // holds the event a write-one-clear cannot take it down
   always_comb
   begin
      frame_sts_nxt = frame_sts_r;
      if (wr_pmc && hwdata[wake_pkg::PMC_STS_BIT])
         frame_sts_nxt = 1'b0;
      if (sys_clear)
         frame_sts_nxt = 1'b0;
      if (wake_frame_source)
         frame_sts_nxt = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         frame_sts_r <= wake_pkg::PMC_RESET[wake_pkg::PMC_STS_BIT];
      else
         frame_sts_r <= frame_sts_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Device ready

   // Any reset source restarts the settling count, so ready reads zero
   ready_sequencer #(
      .CYCLES(STABLE_CYCLES),
      .CNT_W(12)
   ) u_ready (
      .hclk(hclk),
      .hresetn(hresetn),
      .restart(sys_clear),
      .ready(ready)
   );

   // Ready edge detector for the interrupt source
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ready_d_r <= 1'b0;
      else
         ready_d_r <= ready;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and clear

   // A wake event qualifies on its frame enable alone, never on the pin enable
   assign wake_cond = frame_sts_r && frame_en_r;
   assign wake_rise = wake_cond && !wake_cond_d_r;

   always_comb
   begin
      int_set = '0;
      int_set[wake_pkg::INT_READY_BIT] = ready && !ready_d_r;
      int_set[wake_pkg::INT_WAKE_BIT] = wake_rise;
   end

   // Set wins over a clear arriving in the same cycle
   always_comb
   begin
      interrupt_status_reg_nxt = interrupt_status_reg_r;
      if (wr_int_clr)
         interrupt_status_reg_nxt = interrupt_status_reg_r & ~hwdata[INT_W_L-1:0];
      if (sys_clear)
         interrupt_status_reg_nxt = '0;
      interrupt_status_reg_nxt = interrupt_status_reg_nxt | int_set;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         interrupt_status_reg_r <= wake_pkg::INT_RESET;
      else
         interrupt_status_reg_r <= interrupt_status_reg_nxt;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_en_r <= wake_pkg::INT_RESET;
      else if (sys_clear)
         int_en_r <= wake_pkg::INT_RESET;
      else if (wr_int_en)
         int_en_r <= hwdata[INT_W_L-1:0];
   end

   // Level interrupt, registered from the next-state so it tracks status
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(interrupt_status_reg_nxt & int_en_r);
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake indication and pin driver

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wake_cond_d_r <= 1'b0;
      else
         wake_cond_d_r <= wake_cond;
   end

   // Pulse timer restarts on each new event, and is dropped as soon as the
   // status or its enable goes away
   wake_pulse_timer #(
      .CYCLES(PULSE_CYCLES),
      .CNT_W(PULSE_CNT_W)
   ) u_pulse (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(wake_rise),
      .abort(!wake_cond),
      .busy(pulse_busy)
   );

   // Pulsed or static indication, gated by the pin enable
   assign indicate = pin_en_r && (pulse_sel_r ? pulse_busy : wake_cond);

   // Open-drain pulls low only while active; push-pull always drives,
   // with the polarity bit choosing the active level
   always_comb
   begin
      if (!drive_type_r)
      begin
         pin_o_nxt = 1'b0;
         pin_oe_nxt = indicate;
      end
      else
      begin
         pin_o_nxt = polarity_r ? indicate : !indicate;
         pin_oe_nxt = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wake_event_output_o <= 1'b0;
         wake_event_output_oe <= 1'b0;
      end
      else
      begin
         wake_event_output_o <= pin_o_nxt;
         wake_event_output_oe <= pin_oe_nxt;
      end
   end

endmodule : wake_event_output_control

// [test/wake_partner.sv]
`timescale 1ns/100ps
module wake_partner (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic mac_event,
   input wire logic mac_clear,
   input wire logic pin_o,
   input wire logic pin_oe,
   output logic wake_frame_source,
   output logic pin
);
   ////////////////////////////////////////////////////////////////////////////////
   // Board pull-up lifts the wired-or pin whenever nobody drives it
   assign pin = pin_oe ? pin_o : 1'b1;

   // The MAC keeps its event pending until software clears it there
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wake_frame_source <= 1'b0;
      else if (mac_clear)
         wake_frame_source <= 1'b0;
      else if (mac_event)
         wake_frame_source <= 1'b1;
   end
endmodule : wake_partner

// [test/wake_checker_assertions.sv]
`timescale 1ns/100ps
module wake_checker #(
   parameter int PULSE_CYCLES = wake_pkg::PULSE_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic wake_frame_source,
   input wire logic wake_event_output_o,
   input wire logic wake_event_output_oe
);
   logic [2:0] wr_r;
   logic [31:0] cfg_r;
   logic [31:0] cfg_old_r;
   logic [2:0] still_r;
   int run_r;
   logic take;
   logic calm;
   logic ind;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Which control register the current write data phase targets
   assign take = hsel && htrans[1] && hready && hwrite;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wr_r <= 3'h0;
      else
         wr_r <= {take && haddr[11:0] == wake_pkg::RESET_CONTROL_OFS,
            take && haddr[11:0] == wake_pkg::HW_CONFIG_OFS,
            take && haddr[11:0] == wake_pkg::PMC_OFS};
   end
   // Shadow of the pin controls; internal resets land late, hence calm
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cfg_r <= 32'h0;
      else if (wr_r[0])
         cfg_r <= hwdata & 32'h0000_024E;
      else if (wr_r[1] && hwdata[0])
         cfg_r <= cfg_r & 32'h0000_0044;
      else if (wr_r[2] && hwdata[0])
         cfg_r <= 32'h0;
   end
   // Settling time of the controls and length of the active run
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_old_r <= 32'h0;
         still_r <= 3'h0;
         run_r <= 0;
      end
      else
      begin
         cfg_old_r <= cfg_r;
         still_r <= (cfg_r != cfg_old_r) ? 3'h0 : still_r + 3'(still_r != 3'h7);
         run_r <= ind ? run_r + int'(run_r < 1000) : 0;
      end
   end
   assign calm = still_r >= 3'h4 && cfg_r == cfg_old_r;
   assign ind = cfg_r[6] ? wake_event_output_o == cfg_r[2] : wake_event_output_oe;
   ////////////////////////////////////////////////////////////////////////////////
   sequence src_held;
      wake_frame_source [*6];
   endsequence
   sequence pin_armed;
      calm && cfg_r[1] && cfg_r[9];
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_no_wait: assert property ($past(hresetn) |-> hreadyout)
      else $error("wait state inserted");
   a_drain_low: assert property (calm && !cfg_r[6] |-> !wake_event_output_o)
      else $error("open-drain pin driven high");
   a_push_drives: assert property (calm && cfg_r[6] |-> wake_event_output_oe)
      else $error("push-pull pin not driven");
   a_pin_gated: assert property (calm && !cfg_r[1] |-> !ind)
      else $error("disabled pin active");
   a_clear_idle: assert property (calm && !cfg_r[9] |-> !ind)
      else $error("pin active without frame enable");
   a_event_shows: assert property ($rose(wake_frame_source) ##0 pin_armed |-> ##[1:6] ind)
      else $error("event did not reach pin");
   a_static_hold: assert property (src_held ##0 pin_armed ##0 !cfg_r[3] |-> ind)
      else $error("static indication dropped");
   a_pulse_len: assert property (calm && cfg_r[3] |-> run_r <= PULSE_CYCLES + 1)
      else $error("pulse too long");
endmodule : wake_checker

bind wake_event_output_control wake_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .wake_frame_source(wake_frame_source),
   .wake_event_output_o(wake_event_output_o), .wake_event_output_oe(wake_event_output_oe)
);

// [test/testbench.sv]
`timescale 1ns/100ps
module testbench;
   localparam int PC = 20;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic wake_o;
   logic wake_oe;
   logic irq;
   logic src;
   logic pin;
   logic mac_event;
   logic mac_clear;
   logic [31:0] r;
   logic [31:0] cfg;
   logic act;
   int fails;
   int num_checks;
   int n;
   int m;
   ////////////////////////////////////////////////////////////////////////////////
   wake_event_output_control #(.PULSE_CYCLES(PC), .STABLE_CYCLES(10)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wake_frame_source(src),
      .wake_event_output_o(wake_o), .wake_event_output_oe(wake_oe), .irq(irq)
   );
   wake_partner i_far (
      .hclk(hclk), .hresetn(hresetn), .mac_event(mac_event), .mac_clear(mac_clear),
      .pin_o(wake_o), .pin_oe(wake_oe), .wake_frame_source(src), .pin(pin)
   );
   // Free-running 25 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   task expire;
      fails++;
      conclude();
   endtask : expire
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task tick(input int k);
      repeat (k) @(posedge hclk);
   endtask : tick
   // Bounded wait for hready; the slave decides its own pace
   task wait_rdy;
      int w;
      w = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         w++;
         if (w > 50)
            expire();
         @(posedge hclk);
      end
   endtask : wait_rdy
   // One single word transfer, entered just after a rising edge
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] v);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      v = hrdata;
   endtask : ahb
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      ahb(1'b1, a, d, v);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] v;
      ahb(1'b0, a, 32'h0, v);
      check(v, e);
   endtask : rd
   // One-cycle request to the MAC model: raise or drop its event
   task mac(input logic raise);
      if (raise)
         mac_event <= 1'b1;
      else
         mac_clear <= 1'b1;
      tick(1);
      mac_event <= 1'b0;
      mac_clear <= 1'b0;
   endtask : mac
   // Poll only the control register until the device is up
   task wait_ready;
      r = 32'h0;
      for (n = 0; r[0] !== 1'b1; n++)
      begin
         if (n == 100)
            expire();
         ahb(1'b0, wake_pkg::PMC_OFS, 32'h0, r);
      end
   endtask : wait_ready
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, mac_event, mac_clear} = '0;
      hsize = 3'h2;
      fails = 0;
      num_checks = 0;
      tick(3);
      hresetn <= 1'b1;
      tick(2);
      rd(wake_pkg::PMC_OFS, 32'h0);
      rd(wake_pkg::HW_CONFIG_OFS, 32'h0);
      wait_ready();
      rd(wake_pkg::HW_CONFIG_OFS, 32'h0800_0000);
      rd(wake_pkg::INT_STATUS_OFS, 32'h1);
      wr(wake_pkg::INT_ENABLE_OFS, 32'h3);
      tick(2);
      check(32'(irq), 32'h1);
      wr(wake_pkg::INT_CLEAR_OFS, 32'h1);
      tick(2);
      check(32'(irq), 32'h0);
      wr(wake_pkg::PMC_OFS, 32'hFFFF_FFFF);
      rd(wake_pkg::PMC_OFS, 32'h0000_024F);
      rd(12'h100, 32'h0);
      // Every drive type and polarity, static indication
      for (m = 0; m < 4; m++)
      begin
         act = (m == 3);
         cfg = 32'h0202 | (m[1] ? 32'h40 : 32'h0) | (m[0] ? 32'h4 : 32'h0);
         wr(wake_pkg::PMC_OFS, cfg);
         tick(4);
         check(32'(pin), 32'(!act));
         mac(1'b1);
         tick(4);
         check(32'(pin), 32'(act));
         wr(wake_pkg::PMC_OFS, cfg | 32'h20);
         rd(wake_pkg::PMC_OFS, cfg | 32'h21);
         mac(1'b0);
         wr(wake_pkg::PMC_OFS, cfg | 32'h20);
         tick(4);
         rd(wake_pkg::PMC_OFS, cfg | 32'h1);
         check(32'(pin), 32'(!act));
      end
      // Dropping the frame enable releases an active pin
      mac(1'b1);
      tick(4);
      check(32'(pin), 32'h1);
      wr(wake_pkg::PMC_OFS, 32'h046);
      tick(4);
      check(32'(pin), 32'h0);
      mac(1'b0);
      wr(wake_pkg::PMC_OFS, 32'h064);
      // Pin disabled: interrupt status still set
      wr(wake_pkg::INT_CLEAR_OFS, 32'h3);
      wr(wake_pkg::PMC_OFS, 32'h244);
      mac(1'b1);
      tick(4);
      check(32'(pin), 32'h0);
      rd(wake_pkg::INT_STATUS_OFS, 32'h2);
      check(32'(irq), 32'h1);
      mac(1'b0);
      wr(wake_pkg::PMC_OFS, 32'h264);
      wr(wake_pkg::INT_CLEAR_OFS, 32'h2);
      tick(2);
      check(32'(irq), 32'h0);
      // Pulse mode: active for exactly the timed length while the event stays
      wr(wake_pkg::PMC_OFS, 32'h24E);
      tick(4);
      mac(1'b1);
      for (n = 0; pin !== 1'b1 && n < 10; n++)
         tick(1);
      for (n = 0; pin === 1'b1 && n < 100; n++)
         tick(1);
      check(n, PC);
      rd(wake_pkg::PMC_OFS, 32'h26F);
      mac(1'b0);
      wr(wake_pkg::PMC_OFS, 32'h26E);
      // Soft reset keeps drive type and polarity, digital reset clears all
      wr(wake_pkg::HW_CONFIG_OFS, 32'h1);
      tick(2);
      rd(wake_pkg::PMC_OFS, 32'h44);
      rd(wake_pkg::HW_CONFIG_OFS, 32'h0);
      wait_ready();
      wr(wake_pkg::RESET_CONTROL_OFS, 32'h1);
      tick(2);
      rd(wake_pkg::PMC_OFS, 32'h0);
      wait_ready();
      conclude();
   end
endmodule : testbench
